// file: pmc_pkg.sv
// Constants, types and decode tables for the power mode control registers.
// Assumes one 25 MHz clock; a wait "state" is one clock cycle.
//
// How it works
// - Reset loads 0x07 and 0xF0 into registers
// - Standby bit 0: sleep or subsleep
// - Standby bit 1: standby/watch, or watch
// - Wait code picks 8192..131072, 2, 8, 16
// - Hold CPU and peripherals for wait
// - Low-speed bit picks clock after watch
// - First register bit 2 reads one
// - Medium divider field: 16, 32, 64, 128
// - Second register bits 7..5 read one
// - Noise bit: sample watch clock /16 or /4
// - Direct off: sleep enters a low-power mode, but standby with low speed stays active
// - Direct from high: medium or subactive
// - Direct from medium: high or subactive
// - Direct from subactive: high or medium
// - Medium bit picks mode after wake
// - Subactive divider field: /8, /4, /2
// - Subactive divider locked while in subactive
// - Watch-select bit splits standby from watch
package pmc_pkg;

    // ========================================================
    // Bus and register map
    localparam int          PMC_ADDR_W    = 20;      // Byte address width
    localparam logic [15:0] PMC_IDX_A     = 16'hFFF0; // Index, first reg
    localparam logic [15:0] PMC_IDX_B     = 16'hFFF1; // Index, second reg
    localparam logic [7:0]  PMC_RST_A     = 8'h07;   // Reset, first reg
    localparam logic [7:0]  PMC_RST_B     = 8'hF0;   // Reset, second reg
    localparam logic [7:0]  PMC_FIXED_A   = 8'h04;   // Bit 2 reads one
    localparam logic [7:0]  PMC_FIXED_B   = 8'hE0;   // Bits 7..5 read one

    // ========================================================
    // Field positions, first register
    localparam int PMC_A_DEEP_HALT_SELECT = 7;                   // Deep halt select
    localparam int PMC_A_STS  = 4;                   // Settle wait, LSB
    localparam int PMC_A_LOW_SPEED_SELECT = 3;                   // Low speed select
    localparam int PMC_A_MA   = 0;                   // Mid divider, LSB
    // Field positions, second register
    localparam int PMC_B_NES  = 4;                   // Noise filter rate
    localparam int PMC_B_DT   = 3;                   // Direct transfer
    localparam int PMC_B_MS   = 2;                   // Medium speed select
    localparam int PMC_B_SA   = 0;                   // Sub divider, LSB

    // ========================================================
    // Short settle waits in clock cycles
    localparam logic [17:0] PMC_WAIT_2  = 18'h00002; // Code 101
    localparam logic [17:0] PMC_WAIT_8  = 18'h00008; // Code 110
    localparam logic [17:0] PMC_WAIT_16 = 18'h00010; // Code 111

    // Divide ratios reported on the outputs
    localparam logic [7:0] PMC_DIV_16  = 8'h10;      // Medium /16
    localparam logic [7:0] PMC_DIV_32  = 8'h20;      // Medium /32
    localparam logic [7:0] PMC_DIV_64  = 8'h40;      // Medium /64
    localparam logic [7:0] PMC_DIV_128 = 8'h80;      // Medium /128
    localparam logic [3:0] PMC_SDIV_8  = 4'h8;       // Sub /8
    localparam logic [3:0] PMC_SDIV_4  = 4'h4;       // Sub /4
    localparam logic [3:0] PMC_SDIV_2  = 4'h2;       // Sub /2
    localparam logic [4:0] PMC_NDIV_16 = 5'h10;      // Noise /16
    localparam logic [4:0] PMC_NDIV_4  = 5'h04;      // Noise /4

    // ========================================================
    // Power modes; each sleep mode is one bit from its active mode
    typedef enum logic [3:0] {
        PMC_ACT_HIGH = 4'h0,                         // Active high speed
        PMC_SLP_HIGH = 4'h1,                         // Sleep high speed
        PMC_SETTLE   = 4'h3,                         // Oscillator wait
        PMC_STANDBY  = 4'h2,                         // Standby
        PMC_WATCH    = 4'h6,                         // Watch
        PMC_SUBACT   = 4'h7,                         // Subactive
        PMC_SUBSLP   = 4'h5,                         // Subsleep
        PMC_ACT_MED  = 4'h4,                         // Active medium
        PMC_SLP_MED  = 4'hC                          // Sleep medium
    } pmc_mode_t;

endpackage

// file: pmc_power_mode_ctrl.sv
// Power mode control registers and the power mode sequencer.
// Assumes an APB3 master on pclk, a same-clock sleep strobe and wake
// request from the CPU core, and the timer A watch-select bit.
`timescale 1ns/1ps

module pmc_power_mode_ctrl
    import pmc_pkg::*;
#(
    parameter logic [17:0] WAIT_8K   = 18'd8192,    // Code 000 wait
    parameter logic [17:0] WAIT_16K  = 18'd16384,   // Code 001 wait
    parameter logic [17:0] WAIT_32K  = 18'd32768,   // Code 010 wait
    parameter logic [17:0] WAIT_64K  = 18'd65536,   // Code 011 wait
    parameter logic [17:0] WAIT_128K = 18'd131072   // Code 100 wait
)(
    input  wire logic                  pclk,            // System clock
    input  wire logic                  presetn,         // Async reset, low
    input  wire logic [PMC_ADDR_W-1:0] paddr,           // APB byte address
    input  wire logic                  psel,            // APB select
    input  wire logic                  penable,         // APB access phase
    input  wire logic                  pwrite,          // APB write
    input  wire logic [31:0]           pwdata,          // APB write data
    output logic      [31:0]           prdata,          // APB read data
    output logic                       pready,          // APB ready
    output logic                       pslverr,         // APB error
    input  wire logic                  sleep_strobe,    // Sleep executed
    input  wire logic                  wake_request,    // Accepted interrupt
    input  wire logic                  watch_select_bit, // Timer A select
    output logic      [3:0]            power_mode_q,    // Current mode
    output logic                       cpu_hold_q,      // CPU stopped
    output logic                       periph_hold_q,   // Peripherals held
    output logic                       osc_run_q,       // System osc on
    output logic                       cpu_on_subclk_q, // CPU on subclock
    output logic      [7:0]            mid_div_ratio_q, // Medium divide
    output logic      [3:0]            sub_div_ratio_q, // Subactive divide
    output logic      [4:0]            noise_div_q      // Watch sample div
);

    // ========================================================
    // Decode functions
    // Settle wait length for a wait code
    function automatic logic [17:0] wait_len(input logic [2:0] code);
        logic [17:0] n;
        n = PMC_WAIT_16;
        unique case (code)
            3'b000:  n = WAIT_8K;
            3'b001:  n = WAIT_16K;
            3'b010:  n = WAIT_32K;
            3'b011:  n = WAIT_64K;
            3'b100:  n = WAIT_128K;
            3'b101:  n = PMC_WAIT_2;   // External clock input mode
            3'b110:  n = PMC_WAIT_8;
            3'b111:  n = PMC_WAIT_16;
        endcase
        return n;
    endfunction

    // True for either active mode
    function automatic logic is_active(input pmc_mode_t m);
        return (m == PMC_ACT_HIGH) || (m == PMC_ACT_MED);
    endfunction

    // ========================================================
    // Register fields
    logic        deep_halt_select_q;        // Deep halt select
    logic [2:0]  sts_q;         // Settle wait code
    logic        low_speed_select_q;        // Low speed select
    logic [1:0]  ma_q;          // Mid divider code
    logic        noise_filter_rate_q;       // Noise filter rate
    logic        direct_transfer_enable_q;        // Direct transfer enable
    logic        medium_speed_select_q;        // Medium speed select
    logic [1:0]  sa_q;          // Sub divider code
    pmc_mode_t   mode_q;        // Sequencer state
    pmc_mode_t   mode_d;        // Next sequencer state
    logic [17:0] cnt_q;         // Settle cycles left
    logic [17:0] cnt_d;         // Next settle count

    // ========================================================
    // APB decode
    wire         hit_a    = (paddr[PMC_ADDR_W-1:2] == {2'b00, PMC_IDX_A});
    wire         hit_b    = (paddr[PMC_ADDR_W-1:2] == {2'b00, PMC_IDX_B});
    wire         hit      = hit_a || hit_b;
    wire         setup    = psel && !penable;
    wire         commit   = psel && penable && pready && pwrite && hit;
    wire         wr_a     = commit && hit_a;
    wire         wr_b     = commit && hit_b;
    // Divider code is frozen while the CPU runs from it
    wire         sa_lock  = (mode_q == PMC_SUBACT);
    wire [7:0]   rd_a     = {deep_halt_select_q, sts_q, low_speed_select_q, 1'b0, ma_q}
                            | PMC_FIXED_A;
    wire [7:0]   rd_b     = {3'b000, noise_filter_rate_q, direct_transfer_enable_q, medium_speed_select_q, sa_q}
                            | PMC_FIXED_B;
    wire [7:0]   rd_byte  = hit_a ? rd_a : (hit_b ? rd_b : 8'h00);

    // ========================================================
    // Bus answer: one access cycle, every answer from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !hit;   // Unmapped address errors
            if (setup)
            begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ========================================================
    // Register writes; reserved bits have no storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deep_halt_select_q  <= PMC_RST_A[PMC_A_DEEP_HALT_SELECT];
            sts_q   <= PMC_RST_A[PMC_A_STS +: 3];
            low_speed_select_q  <= PMC_RST_A[PMC_A_LOW_SPEED_SELECT];
            ma_q    <= PMC_RST_A[PMC_A_MA +: 2];
            noise_filter_rate_q <= PMC_RST_B[PMC_B_NES];
            direct_transfer_enable_q  <= PMC_RST_B[PMC_B_DT];
            medium_speed_select_q  <= PMC_RST_B[PMC_B_MS];
            sa_q    <= PMC_RST_B[PMC_B_SA +: 2];
        end
        else
        begin
            if (wr_a)
            begin
                deep_halt_select_q <= pwdata[PMC_A_DEEP_HALT_SELECT];
                sts_q  <= pwdata[PMC_A_STS +: 3];
                low_speed_select_q <= pwdata[PMC_A_LOW_SPEED_SELECT];
                ma_q   <= pwdata[PMC_A_MA +: 2];
            end
            if (wr_b)
            begin
                noise_filter_rate_q <= pwdata[PMC_B_NES];
                direct_transfer_enable_q  <= pwdata[PMC_B_DT];
                medium_speed_select_q  <= pwdata[PMC_B_MS];
                if (!sa_lock)
                begin
                    sa_q <= pwdata[PMC_B_SA +: 2];
                end
            end
        end
    end

    // ========================================================
    // Sleep decode; bits are those present in the strobe cycle
    wire deep_sel   = deep_halt_select_q && watch_select_bit;
    wire stby_sel   = deep_halt_select_q && !watch_select_bit && !low_speed_select_q;
    wire to_sub_dir = deep_sel && low_speed_select_q;
    pmc_mode_t act_tgt;     // Active mode chosen by the medium bit
    pmc_mode_t slp_tgt;     // Sleep mode chosen by the medium bit
    pmc_mode_t plain_tgt;   // Target from active, direct off
    assign act_tgt = medium_speed_select_q ? PMC_ACT_MED : PMC_ACT_HIGH;
    assign slp_tgt = medium_speed_select_q ? PMC_SLP_MED : PMC_SLP_HIGH;
    // Standby with low speed set is undefined; the CPU stays active
    assign plain_tgt = !deep_halt_select_q  ? slp_tgt :
                       deep_sel ? PMC_WATCH :
                       stby_sel ? PMC_STANDBY : mode_q;

    // ========================================================
    // Mode sequencer next state
    always_comb
    begin
        mode_d = mode_q;
        cnt_d  = (cnt_q != 18'h00000) ? cnt_q - 18'h00001 : cnt_q;
        unique case (mode_q)
            PMC_ACT_HIGH:
            begin
                if (sleep_strobe)
                begin
                    if (direct_transfer_enable_q && !deep_halt_select_q && medium_speed_select_q && !low_speed_select_q)
                        mode_d = PMC_ACT_MED;
                    else if (direct_transfer_enable_q && to_sub_dir)
                        mode_d = PMC_SUBACT;
                    else
                        mode_d = plain_tgt;
                end
            end
            PMC_ACT_MED:
            begin
                if (sleep_strobe)
                begin
                    if (direct_transfer_enable_q && !deep_halt_select_q && !medium_speed_select_q && !low_speed_select_q)
                        mode_d = PMC_ACT_HIGH;
                    else if (direct_transfer_enable_q && to_sub_dir)
                        mode_d = PMC_SUBACT;
                    else
                        mode_d = plain_tgt;
                end
            end
            PMC_SUBACT:
            begin
                if (sleep_strobe)
                begin
                    if (direct_transfer_enable_q && deep_sel && !low_speed_select_q)
                        mode_d = act_tgt;
                    else if (deep_halt_select_q)
                        mode_d = PMC_WATCH;
                    else
                        mode_d = PMC_SUBSLP;
                end
            end
            PMC_SLP_HIGH, PMC_SLP_MED:
            begin
                // Sleep keeps the oscillator, so wake is immediate
                if (wake_request)
                    mode_d = (mode_q == PMC_SLP_MED) ? PMC_ACT_MED
                                                     : PMC_ACT_HIGH;
            end
            PMC_SUBSLP:
            begin
                if (wake_request)
                    mode_d = PMC_SUBACT;
            end
            PMC_STANDBY:
            begin
                if (wake_request)
                begin
                    mode_d = PMC_SETTLE;
                    cnt_d  = wait_len(sts_q) - 18'h00001;
                end
            end
            PMC_WATCH:
            begin
                if (wake_request && low_speed_select_q)
                    mode_d = PMC_SUBACT;
                else if (wake_request)
                begin
                    mode_d = PMC_SETTLE;
                    cnt_d  = wait_len(sts_q) - 18'h00001;
                end
            end
            PMC_SETTLE:
            begin
                // CPU and peripherals stay held until the count ends
                if (cnt_q == 18'h00000)
                    mode_d = act_tgt;
            end
            default:
            begin
                mode_d = PMC_ACT_HIGH;
                cnt_d  = 18'h00000;
            end
        endcase
    end

    // ========================================================
    // Status outputs derived from the next mode and the register fields
    wire sub_d  = (mode_d == PMC_SUBACT) || (mode_d == PMC_SUBSLP);
    wire stop_d = (mode_d == PMC_STANDBY) || (mode_d == PMC_WATCH);
    wire halt_d = !is_active(mode_d) && (mode_d != PMC_SUBACT);
    wire [7:0] mid_d = (ma_q == 2'b00) ? PMC_DIV_16 :
                       (ma_q == 2'b01) ? PMC_DIV_32 :
                       (ma_q == 2'b10) ? PMC_DIV_64 : PMC_DIV_128;
    wire [3:0] sdiv_d = sa_q[1] ? PMC_SDIV_2 :
                        (sa_q[0] ? PMC_SDIV_4 : PMC_SDIV_8);
    wire [4:0] ndiv_d = noise_filter_rate_q ? PMC_NDIV_4 : PMC_NDIV_16;

    // ========================================================
    // Sequencer state and registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q          <= PMC_ACT_HIGH;
            cnt_q           <= 18'h00000;
            power_mode_q    <= PMC_ACT_HIGH;
            cpu_hold_q      <= 1'b0;
            periph_hold_q   <= 1'b0;
            osc_run_q       <= 1'b1;
            cpu_on_subclk_q <= 1'b0;
            mid_div_ratio_q <= PMC_DIV_128;
            sub_div_ratio_q <= PMC_SDIV_8;
            noise_div_q     <= PMC_NDIV_4;
        end
        else
        begin
            mode_q          <= mode_d;
            cnt_q           <= cnt_d;
            power_mode_q    <= mode_d;
            cpu_hold_q      <= halt_d;
            periph_hold_q   <= stop_d || (mode_d == PMC_SETTLE);
            osc_run_q       <= !stop_d && !sub_d;
            cpu_on_subclk_q <= sub_d;
            mid_div_ratio_q <= mid_d;
            sub_div_ratio_q <= sdiv_d;
            noise_div_q     <= ndiv_d;
        end
    end

    // ========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Reserved bits of both registers always read as one
    a_fixed_bits_read: assert property (
        (setup && hit_a) |=> (prdata[2] == 1'b1))
        else $error("first register bit 2 read as zero");
    a_fixed_top_read: assert property (
        (setup && hit_b) |=> (prdata[7:5] == 3'b111))
        else $error("second register top bits read as zero");
    // Sleep in active mode with standby clear goes to a sleep mode
    a_sleep_entry: assert property (
        (sleep_strobe && is_active(mode_q) && !deep_halt_select_q && !direct_transfer_enable_q)
        |=> (mode_q == (medium_speed_select_q ? PMC_SLP_MED : PMC_SLP_HIGH)))
        else $error("sleep instruction did not enter sleep");
    // Standby bit with watch select sends subactive to watch
    a_sub_to_watch: assert property (
        (sleep_strobe && mode_q == PMC_SUBACT && deep_halt_select_q && !direct_transfer_enable_q)
        |=> (mode_q == PMC_WATCH))
        else $error("subactive sleep did not enter watch");
    // Watch select splits standby from watch
    a_standby_split: assert property (
        (sleep_strobe && is_active(mode_q) && deep_halt_select_q && !low_speed_select_q
         && !direct_transfer_enable_q) |=> (mode_q == (watch_select_bit ? PMC_WATCH
                                                      : PMC_STANDBY)))
        else $error("standby and watch chosen wrongly");
    // Short wait code 110 holds the CPU for exactly eight cycles
    a_short_wait: assert property (
        (mode_q == PMC_STANDBY && wake_request && sts_q == 3'b110)
        |=> (mode_q == PMC_SETTLE)[*8] ##1 (mode_q == act_tgt))
        else $error("eight state wait has the wrong length");
    a_settle_held: assert property (
        (mode_q == PMC_SETTLE) |-> (cpu_hold_q && periph_hold_q))
        else $error("CPU released during oscillator wait");
    // Direct transfer from subactive picks the active speed
    a_direct_sub: assert property (
        (sleep_strobe && mode_q == PMC_SUBACT && direct_transfer_enable_q && deep_halt_select_q
         && watch_select_bit && !low_speed_select_q)
        |=> (mode_q == (medium_speed_select_q ? PMC_ACT_MED : PMC_ACT_HIGH)))
        else $error("direct transfer from subactive went wrong");
    // Divider code cannot change in subactive mode
    a_sub_lock: assert property (
        (mode_q == PMC_SUBACT && mode_d == PMC_SUBACT) |=> $stable(sa_q))
        else $error("sub divider changed in subactive mode");
    // Watch wake with low speed goes straight to subactive
    a_watch_low: assert property (
        (mode_q == PMC_WATCH && wake_request && low_speed_select_q)
        |=> (mode_q == PMC_SUBACT) ##1 cpu_on_subclk_q)
        else $error("watch wake ignored low speed select");
    // Stop modes and subactive have the system oscillator off
    a_osc_stopped: assert property (
        (mode_q == PMC_STANDBY || mode_q == PMC_WATCH
         || mode_q == PMC_SUBACT) |-> !osc_run_q)
        else $error("system oscillator left running in a stop mode");
    // Wake from sleep medium returns to active medium, not high speed
    a_sleep_wake: assert property (
        (wake_request && mode_q == PMC_SLP_MED)
        |=> (mode_q == PMC_ACT_MED))
        else $error("sleep medium did not wake to active medium");
    // An unmapped word answers at once with an error and zero data
    a_unmapped_err: assert property (
        (setup && !hit) |=> (pready && pslverr && prdata == 32'h0000_0000))
        else $error("unmapped address did not report an error");

    c_standby_wake: cover property (
        (mode_q == PMC_STANDBY) ##1 (mode_q == PMC_SETTLE)[*2]);
    c_direct_high_med: cover property (
        (mode_q == PMC_ACT_HIGH) ##1 (mode_q == PMC_ACT_MED));
    c_sub_sleep: cover property (
        (mode_q == PMC_SUBACT) ##1 (mode_q == PMC_SUBSLP));
    c_bad_addr: cover property (pready && pslverr);
    c_watch_to_sub: cover property (
        (mode_q == PMC_WATCH) ##1 (mode_q == PMC_SUBACT));

endmodule // pmc_power_mode_ctrl

// file: pmc_cpu_model.sv
// CPU core model: sleep strobe, wake request, timer A watch select.
// Assumes pclk from the bench; the bench calls the tasks below.
`timescale 1ns/1ps
module pmc_cpu_model (
    input  wire logic pclk,             // System clock
    output logic      sleep_strobe,     // Sleep executed
    output logic      wake_request,     // Accepted interrupt
    output logic      watch_select_bit  // Timer A select
);
    // ==========================================================
    // Idle levels at time zero
    initial
    begin
        sleep_strobe = 1'b0;
        wake_request = 1'b0;
        watch_select_bit = 1'b0;
    end
    // One-cycle sleep pulse; select stays as a level afterwards
    task automatic sleep_op(input logic ws);
        @(posedge pclk);
        sleep_strobe <= 1'b1;
        watch_select_bit <= ws;
        @(posedge pclk);
        sleep_strobe <= 1'b0;
    endtask
    // One-cycle accepted interrupt
    task automatic wake_op();
        @(posedge pclk);
        wake_request <= 1'b1;
        @(posedge pclk);
        wake_request <= 1'b0;
    endtask
endmodule // pmc_cpu_model

// file: power_mode_control_regs_test.sv
// Self-checking bench for the power mode control registers.
// Assumes the design package, the design and the CPU model compile first.
`timescale 1ns/1ps
module power_mode_control_regs_test import pmc_pkg::*;;
    // ==========================================================
    // Signals and bench state
    localparam logic [19:0] AD_A = 20'h3FFC0; // First register
    localparam logic [19:0] AD_B = 20'h3FFC4; // Second register
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er, slp, wake, wsel;
    logic hold, phold, osc, subc; // Hold, oscillator and subclock flags
    logic [19:0] paddr = 20'h0; // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd; // APB data
    logic [3:0] mode, sub; // Mode and sub divide
    logic [7:0] mid, va, vb; // Medium divide, random values
    logic [4:0] noise; // Noise sample divide
    logic [23:0] st; // Step: A, B, flags, expected mode
    logic [23:0] steps [14] = '{24'h000001, 24'h000020, 24'h00040C,
        24'h000024, 24'h000840, 24'h000C04, 24'h000840, 24'hE00002,
        24'h000023, 24'hE80016, 24'h000027, 24'h680015, 24'h000027,
        24'hE00C14};
    int fails = 0, checks = 0;
    always #20 pclk = ~pclk;
    // Short settle counts keep the run brief; code 110 is fixed at 8
    pmc_power_mode_ctrl #(.WAIT_8K(18'd20), .WAIT_16K(18'd30),
        .WAIT_32K(18'd40), .WAIT_64K(18'd50), .WAIT_128K(18'd60)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_strobe(slp), .wake_request(wake), .watch_select_bit(wsel),
        .power_mode_q(mode), .cpu_hold_q(hold), .periph_hold_q(phold),
        .osc_run_q(osc), .cpu_on_subclk_q(subc), .mid_div_ratio_q(mid),
        .sub_div_ratio_q(sub), .noise_div_q(noise));
    pmc_cpu_model cpu (.pclk(pclk), .sleep_strobe(slp),
        .wake_request(wake), .watch_select_bit(wsel));
    // ==========================================================
    // Expectations and compares
    function automatic logic [7:0] mid_exp(input logic [1:0] c);
        return 8'h10 << c;
    endfunction
    function automatic logic [3:0] sub_exp(input logic [1:0] c);
        return c[1] ? 4'h2 : (c[0] ? 4'h4 : 4'h8);
    endfunction
    // CPU hold, peripheral hold, oscillator on, subclock, per mode
    function automatic logic [3:0] flags_exp(input logic [3:0] m);
        logic stp, sb;
        stp = (m == PMC_STANDBY) || (m == PMC_WATCH);
        sb = (m == PMC_SUBACT) || (m == PMC_SUBSLP);
        return {!(m == PMC_ACT_HIGH || m == PMC_ACT_MED || m == PMC_SUBACT),
                stp || (m == PMC_SETTLE), !stp && !sb, sb};
    endfunction
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_mode(input logic [3:0] e);
        #1;
        checks++;
        if (mode !== e)
        begin
            fails++;
            $display("[ERR] %0t mode %h expected %h", $time, mode, e);
        end
        chk_val({28'h0, hold, phold, osc, subc},
                {28'h0, flags_exp(e)});
    endtask
    // One APB transfer; pready is sampled at rising edges, wait bounded
    task automatic apb(input logic w, input logic [19:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t no pready", $time);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [19:0] a, input logic [31:0] e,
                       input logic ee);
        apb(1'b0, a, 8'h00);
        chk_val(rd, e);
        chk_val({31'h0, er}, {31'h0, ee});
    endtask
    task automatic complete_run();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Main sequence: reset values, random fields, mode walk
    initial
    begin
        void'($urandom(28034));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(AD_A, 32'h07, 1'b0);
        rdc(AD_B, 32'hF0, 1'b0);
        rdc(20'h3FFC8, 32'h0, 1'b1); // Unmapped word
        for (int i = 0; i < 12; i++)
        begin
            va = (i == 0) ? 8'h00 : 8'($urandom);
            vb = (i == 0) ? 8'h00 : 8'($urandom);
            if (va[6:4] == 3'h5) va[4] = 1'b0;
            apb(1'b1, AD_A, va);
            apb(1'b1, AD_B, vb);
            rdc(AD_A, {24'h0, va | 8'h04}, 1'b0);
            rdc(AD_B, {24'h0, vb | 8'hE0}, 1'b0);
            chk_val({24'h0, mid}, {24'h0, mid_exp(va[1:0])});
            chk_val({28'h0, sub}, {28'h0, sub_exp(vb[1:0])});
            chk_val({27'h0, noise}, vb[4] ? 32'h4 : 32'h10);
        end
        // Flags: bit 4 watch select, bit 5 wake, bit 6 keep first reg
        foreach (steps[i])
        begin
            st = steps[i];
            if (st[5]) cpu.wake_op();
            else
            begin
                if (!st[6]) apb(1'b1, AD_A, st[23:16]);
                apb(1'b1, AD_B, st[15:8]);
                cpu.sleep_op(st[4]);
            end
            chk_mode(st[3:0]);
            if (st[3:0] == PMC_SETTLE)
            begin
                repeat (7) @(posedge pclk);
                chk_mode(PMC_SETTLE);
                @(posedge pclk);
                chk_mode(PMC_ACT_HIGH);
            end
            if (i == 10)
            begin
                apb(1'b1, AD_B, 8'h03);
                rdc(AD_B, 32'hE0, 1'b0);
                chk_val({28'h0, sub}, 32'h8);
            end
        end
        complete_run();
    end
    // Watchdog: the whole sequence needs well under 2,500 cycles
    initial
    begin
        #100000;
        fails++;
        complete_run();
    end
endmodule // power_mode_control_regs_test
